// >>> shared/pdct_pkg.sv
package pdct_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] PDCT_ADDR_CTRL = 12'h000;
  localparam logic [11:0] PDCT_ADDR_COUNT = 12'h004;
  localparam logic [11:0] PDCT_ADDR_STATUS = 12'h008;
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int PDCT_BIT_IRQ = 7;
  localparam int PDCT_BIT_MASK = 6;
  localparam int PDCT_BIT_SRC = 5;
  localparam int PDCT_BIT_PIN = 4;
  localparam int PDCT_BIT_PCLR = 3;
  localparam int PDCT_TAP_MSB = 2;
  // ----------------------------------------------------------------
  // Reset and preset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PDCT_COUNT_PRESET = 8'hF0;
  localparam logic [7:0] PDCT_COUNT_RST = 8'hF0;
  localparam logic [2:0] PDCT_TAP_RST = 3'h0;
  localparam logic [6:0] PDCT_PRESC_RST = 7'h00;
  // Input source modes, {source select, pin enable}
  typedef enum logic [1:0] {
    PDCT_MODE_INT = 2'b00,
    PDCT_MODE_GATED = 2'b01,
    PDCT_MODE_OFF = 2'b10,
    PDCT_MODE_PIN = 2'b11
  } pdct_mode_t;
endpackage : pdct_pkg

// >>> src/pdct_timer.sv
// Overview of operation
// - 8-bit down counter after a 7-bit prescaler; software can load it.
// - Counter decrementing to zero sets the request flag, control bit 7.
// - Interrupt reaches core only if flag set, timer mask and core mask clear.
// - Counter keeps decrementing after zero to measure elapsed input clocks.
// - Reading counter never disturbs counting; value stable through the read.
// - Flag stays set until software clears it, never cleared on entry.
// - Flag still sets with mask bit set, usable as polled status.
// - Three select bits pick prescaler tap divide 1 to 128.
// - Prescaler not accessible; control write with bit 3 set clears it.
// - Prescaler-clear bit always reads as zero.
// - Source and pin enable both 0: count internal clock, ignore pin.
// - Pin enable 1, source 0: count internal clock ANDed with pin.
// - Pin enable 0, source 1: all timer inputs blocked.
// - Both 1: internal clock disabled, count falling edges of pin.
// - Prescaler and counter advance on falling edges of selected input.
// - Internal clock to timer keeps running during idle mode.
// - Power-on reset and halt instruction load counter with F0.
// - Flag cleared by any reset or halt; software may set or clear.
// - Mask set by any reset or halt; otherwise program-controlled only.
// - Source, pin enable and tap select keep values through external reset.
// - All control bits except prescaler-clear are readable and writable.
// - Halt instruction also clears the prescaler.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pdct_timer #(
  parameter int CNT_W = 8,
  parameter int PRESC_W = 7
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ext_rst,
  input wire logic cyc_tick,
  input wire logic halt_exec,
  input wire logic idle_mode,
  input wire logic core_irq_mask,
  input wire logic tmr_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tmr_irq,
  output logic core_irq
);
  // ----------------------------------------------------------------
  // Control register and datapath state
  // ----------------------------------------------------------------
  logic tmr_irq_request;
  logic tmr_irq_mask;
  logic tmr_src_select;
  logic tmr_pin_enable;
  logic [2:0] prescaler_tap_sel;
  logic [PRESC_W-1:0] prescaler;
  logic [CNT_W-1:0] counter;
  logic pin_q;
  logic in_edge;
  logic presc_fall;
  logic tap_edge;
  logic hit_zero;
  logic wr_ctrl;
  logic wr_count;
  logic rd_en;
  logic [PRESC_W-1:0] next_prescaler;
  pdct_pkg::pdct_mode_t mode;

  assign mode = pdct_pkg::pdct_mode_t'({tmr_src_select, tmr_pin_enable});

  // APB decode; zero wait states so pready is constant high
  assign pready = 1'b1;
  assign wr_ctrl = psel && penable && pwrite && (paddr == pdct_pkg::PDCT_ADDR_CTRL);
  assign wr_count = psel && penable && pwrite && (paddr == pdct_pkg::PDCT_ADDR_COUNT);
  assign rd_en = psel && !pwrite;
  assign pslverr = psel && penable && (paddr != pdct_pkg::PDCT_ADDR_CTRL)
                   && (paddr != pdct_pkg::PDCT_ADDR_COUNT)
                   && (paddr != pdct_pkg::PDCT_ADDR_STATUS);

  // Pin history for falling-edge detection in external mode
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= tmr_pin;
    end
  end

  // Input selection; idle mode is deliberately not an input here
  always_comb begin
    case (mode)
      pdct_pkg::PDCT_MODE_INT: in_edge = cyc_tick;
      pdct_pkg::PDCT_MODE_GATED: in_edge = cyc_tick && tmr_pin;
      pdct_pkg::PDCT_MODE_OFF: in_edge = 1'b0;
      pdct_pkg::PDCT_MODE_PIN: in_edge = pin_q && !tmr_pin;
      default: in_edge = 1'b0;
    endcase
  end

  // Tap fires when the selected prescaler bit falls (tap select 0 = every edge)
  assign next_prescaler = prescaler + PRESC_W'(1);
  always_comb begin
    presc_fall = 1'b0;
    if (prescaler_tap_sel == 3'h0) begin
      presc_fall = 1'b1;
    end else begin
      presc_fall = prescaler[prescaler_tap_sel - 3'h1] && !next_prescaler[prescaler_tap_sel - 3'h1];
    end
  end
  assign tap_edge = in_edge && presc_fall;
  assign hit_zero = tap_edge && (counter == CNT_W'(1));

  // ----------------------------------------------------------------
  // Prescaler: hidden from software, cleared by write bit 3 or halt
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescaler <= pdct_pkg::PDCT_PRESC_RST;
    end else if (halt_exec) begin
      prescaler <= pdct_pkg::PDCT_PRESC_RST;
    end else if (wr_ctrl && pwdata[pdct_pkg::PDCT_BIT_PCLR]) begin
      prescaler <= pdct_pkg::PDCT_PRESC_RST;
    end else if (in_edge) begin
      prescaler <= next_prescaler;
    end
  end

  // ----------------------------------------------------------------
  // Down counter; wraps through zero and keeps going
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      counter <= pdct_pkg::PDCT_COUNT_RST;
    end else if (halt_exec) begin
      counter <= pdct_pkg::PDCT_COUNT_PRESET;
    end else if (wr_count) begin
      counter <= pwdata[CNT_W-1:0];
    end else if (tap_edge) begin
      counter <= counter - CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Control bits: request and mask follow any reset; others survive ext_rst
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_irq_request <= 1'b0;
      tmr_irq_mask <= 1'b1;
    end else if (ext_rst || halt_exec) begin
      tmr_irq_request <= 1'b0;
      tmr_irq_mask <= 1'b1;
    end else begin
      if (hit_zero) begin
        tmr_irq_request <= 1'b1;
      end else if (wr_ctrl) begin
        tmr_irq_request <= pwdata[pdct_pkg::PDCT_BIT_IRQ];
      end
      if (wr_ctrl) begin
        tmr_irq_mask <= pwdata[pdct_pkg::PDCT_BIT_MASK];
      end
    end
  end

  // Mode and tap bits ignore ext_rst; only power-on clears them
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_src_select <= 1'b0;
      tmr_pin_enable <= 1'b0;
      prescaler_tap_sel <= pdct_pkg::PDCT_TAP_RST;
    end else if (wr_ctrl) begin
      tmr_src_select <= pwdata[pdct_pkg::PDCT_BIT_SRC];
      tmr_pin_enable <= pwdata[pdct_pkg::PDCT_BIT_PIN];
      prescaler_tap_sel <= pwdata[pdct_pkg::PDCT_TAP_MSB:0];
    end
  end

  // Interrupt level outputs
  assign tmr_irq = tmr_irq_request && !tmr_irq_mask;
  assign core_irq = tmr_irq && !core_irq_mask;

  // Read data registered in setup phase, held through access phase
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      case (paddr)
        pdct_pkg::PDCT_ADDR_CTRL: prdata <= {24'h000000, tmr_irq_request, tmr_irq_mask,
          tmr_src_select, tmr_pin_enable, 1'b0, prescaler_tap_sel};
        pdct_pkg::PDCT_ADDR_COUNT: prdata <= {24'h000000, counter};
        pdct_pkg::PDCT_ADDR_STATUS: prdata <= {30'h0000_0000, idle_mode, tmr_irq};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_zero_sets_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (hit_zero && !ext_rst && !halt_exec) |=> tmr_irq_request)
    else $error("flag not set on zero");
  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tmr_irq_request && !wr_ctrl && !ext_rst && !halt_exec) |=> tmr_irq_request)
    else $error("flag dropped without clear");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
    core_irq == (tmr_irq_request && !tmr_irq_mask && !core_irq_mask))
    else $error("core irq wrong");
  a_count_wraps: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tap_edge && counter == 8'h00 && !wr_count && !halt_exec) |=> counter == 8'hFF)
    else $error("counter stopped at zero");
  a_off_mode_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == pdct_pkg::PDCT_MODE_OFF && !wr_count && !halt_exec) |=> $stable(counter))
    else $error("counted while blocked");
  a_halt_preset: assert property (@(posedge ref_clk) disable iff (sys_rst)
    halt_exec |=> (counter == 8'hF0 && prescaler == 7'h00 && tmr_irq_mask))
    else $error("halt preset wrong");
  a_pclr_reads_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rd_en && !penable && paddr == pdct_pkg::PDCT_ADDR_CTRL) |=> !prdata[3])
    else $error("clear bit read as one");
  a_extrst_mask: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ext_rst |=> (tmr_irq_mask && !tmr_irq_request))
    else $error("ext reset mask wrong");
  a_pin_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == pdct_pkg::PDCT_MODE_PIN && !(pin_q && !tmr_pin)) |-> !tap_edge)
    else $error("counted without pin fall");

  // ----------------------------------------------------------------
  // Counter datapath checks
  // ----------------------------------------------------------------
  // One decrement per tap event, never more
  a_count_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tap_edge && !wr_count && !halt_exec) |=> counter == $past(counter) - CNT_W'(1))
    else $error("counter step wrong");

  // Reads and idle cycles leave the count alone
  a_count_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!tap_edge && !wr_count && !halt_exec) |=> $stable(counter))
    else $error("counter moved without tap");

  // Software load lands on the next edge
  a_count_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_count && !halt_exec) |=> counter == $past(pwdata[CNT_W-1:0]))
    else $error("counter load lost");

  // ----------------------------------------------------------------
  // Prescaler checks
  // ----------------------------------------------------------------
  // Clear bit wins over a counting input in the same cycle
  a_presc_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_ctrl && pwdata[pdct_pkg::PDCT_BIT_PCLR] && !halt_exec) |=> prescaler == PRESC_W'(0))
    else $error("prescaler not cleared");

  a_presc_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (in_edge && !halt_exec && !(wr_ctrl && pwdata[pdct_pkg::PDCT_BIT_PCLR]))
    |=> prescaler == $past(next_prescaler))
    else $error("prescaler step wrong");

  // Hidden divider only moves on input events or clears
  a_presc_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!in_edge && !halt_exec && !wr_ctrl) |=> $stable(prescaler))
    else $error("prescaler moved");

  // ----------------------------------------------------------------
  // Input mode checks
  // ----------------------------------------------------------------
  a_int_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == pdct_pkg::PDCT_MODE_INT) |-> (in_edge == cyc_tick))
    else $error("internal mode input wrong");

  a_gated_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == pdct_pkg::PDCT_MODE_GATED) |-> (in_edge == (cyc_tick && tmr_pin)))
    else $error("gated mode input wrong");

  a_off_no_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == pdct_pkg::PDCT_MODE_OFF) |-> !in_edge)
    else $error("blocked mode saw input");

  // Pin mode must ignore the instruction clock entirely
  a_pin_no_tick: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == pdct_pkg::PDCT_MODE_PIN && cyc_tick && !(pin_q && !tmr_pin)) |-> !in_edge)
    else $error("pin mode took tick");

  // Idle mode never gates the timer input
  a_idle_counts: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == pdct_pkg::PDCT_MODE_INT && cyc_tick && idle_mode) |-> in_edge)
    else $error("idle stopped timer");

  // ----------------------------------------------------------------
  // Flag and mask checks
  // ----------------------------------------------------------------
  a_tmr_irq_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tmr_irq == (tmr_irq_request && !tmr_irq_mask))
    else $error("timer irq level wrong");

  // Masked zero still raises the polled flag
  a_masked_poll: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (hit_zero && tmr_irq_mask && !wr_ctrl && !ext_rst && !halt_exec)
    |=> (tmr_irq_request && !tmr_irq))
    else $error("masked flag wrong");

  a_sw_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_ctrl && !pwdata[pdct_pkg::PDCT_BIT_IRQ] && !hit_zero && !ext_rst && !halt_exec)
    |=> !tmr_irq_request)
    else $error("software clear lost");

  a_sw_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_ctrl && pwdata[pdct_pkg::PDCT_BIT_IRQ] && !ext_rst && !halt_exec)
    |=> tmr_irq_request)
    else $error("software set lost");

  a_halt_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    halt_exec |=> !tmr_irq_request)
    else $error("halt left flag set");

  a_mask_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_ctrl && !ext_rst && !halt_exec) |=> tmr_irq_mask == $past(pwdata[pdct_pkg::PDCT_BIT_MASK]))
    else $error("mask write lost");

  // Mask changes only by program, reset or halt
  a_mask_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!wr_ctrl && !ext_rst && !halt_exec) |=> $stable(tmr_irq_mask))
    else $error("mask moved by itself");

  // ----------------------------------------------------------------
  // Control and read-back checks
  // ----------------------------------------------------------------
  a_extrst_keep: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (ext_rst && !wr_ctrl)
    |=> ($stable(tmr_src_select) && $stable(tmr_pin_enable) && $stable(prescaler_tap_sel)))
    else $error("ext reset touched mode");

  a_ctrl_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_ctrl |=> (tmr_src_select == $past(pwdata[pdct_pkg::PDCT_BIT_SRC])
      && tmr_pin_enable == $past(pwdata[pdct_pkg::PDCT_BIT_PIN])
      && prescaler_tap_sel == $past(pwdata[pdct_pkg::PDCT_TAP_MSB:0])))
    else $error("control write lost");

  // Upper read bits are always zero for the byte-wide register
  a_ctrl_upper: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rd_en && !penable && paddr == pdct_pkg::PDCT_ADDR_CTRL) |=> prdata[31:8] == 24'h000000)
    else $error("control upper bits set");

  a_count_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rd_en && !penable && paddr == pdct_pkg::PDCT_ADDR_COUNT)
    |=> prdata == {24'h000000, $past(counter)})
    else $error("count read wrong");

  // Read data stays put through the access phase
  a_read_stable: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !(rd_en && !penable) |=> $stable(prdata))
    else $error("read data moved");
endmodule : pdct_timer
`default_nettype wire

// >>> tb/pdct_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Core stand-in seen by the timer
// ----------------------------------------
module pdct_core_model #(
  parameter logic [15:0] VEC_RUN = 16'h1FF8,
  parameter logic [15:0] VEC_IDLE = 16'h1FF6
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic core_irq,
  input wire logic cli,
  input wire logic wait_req,
  output logic core_irq_mask,
  output logic idle_mode,
  output logic [15:0] vector,
  output logic [7:0] entries
);
  // Entry masks again: the flag stays up, so a reentry storm follows otherwise
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_irq_mask <= 1'b1;
      idle_mode <= 1'b0;
      vector <= 16'h0000;
      entries <= 8'h00;
    end else if (core_irq) begin
      core_irq_mask <= 1'b1;
      idle_mode <= 1'b0;
      vector <= idle_mode ? VEC_IDLE : VEC_RUN;
      entries <= entries + 8'h01;
    end else if (wait_req) begin
      idle_mode <= 1'b1; // Waiting reopens interrupts
      core_irq_mask <= 1'b0;
    end else if (cli) begin
      core_irq_mask <= 1'b0;
    end
  end
endmodule : pdct_core_model
`default_nettype wire

// >>> tb/prescaled_down_counter_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module prescaled_down_counter_timer_tb;
  localparam logic [11:0] AC = pdct_pkg::PDCT_ADDR_CTRL;
  localparam logic [11:0] AN = pdct_pkg::PDCT_ADDR_COUNT;
  logic ref_clk = 0, sys_rst = 1, ext_rst = 0, cyc_tick = 0, halt_exec = 0, tmr_pin = 0;
  logic psel = 0, penable = 0, pwrite = 0, cli = 0, wait_req = 0, pready, pslverr, e;
  logic tmr_irq, core_irq, core_irq_mask, idle_mode;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, v, c;
  logic [15:0] vector;
  logic [7:0] entries;
  int mismatches = 0, n_tests = 0, cyc = 0, n;
  pdct_timer dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ext_rst(ext_rst),
    .cyc_tick(cyc_tick), .halt_exec(halt_exec), .idle_mode(idle_mode),
    .core_irq_mask(core_irq_mask), .tmr_pin(tmr_pin), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tmr_irq(tmr_irq), .core_irq(core_irq));
  pdct_core_model core (.ref_clk(ref_clk), .sys_rst(sys_rst), .core_irq(core_irq),
    .cli(cli), .wait_req(wait_req), .core_irq_mask(core_irq_mask),
    .idle_mode(idle_mode), .vector(vector), .entries(entries));
  // ----------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // Hang guard, well above the longest sequence
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      summarize();
    end
  end
  task summarize;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // APB transfer; data and error taken at the pready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk) penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rd
  // One internal input clock per call step
  task tk(input int k);
    repeat (k) begin
      @(posedge ref_clk) cyc_tick <= 1'b1;
      @(posedge ref_clk) cyc_tick <= 1'b0;
    end
  endtask : tk
  // One-cycle strobe: 0 wait, 1 unmask, 2 halt, 3 external reset
  task pulse(input int s);
    @(posedge ref_clk) {ext_rst, halt_exec, cli, wait_req} <= 4'(1 << s);
    @(posedge ref_clk) {ext_rst, halt_exec, cli, wait_req} <= 4'h0;
    repeat (2) @(posedge ref_clk);
  endtask : pulse
  // Prescaler starts at zero, so tap t fires once every 2**t inputs
  function logic [7:0] left(logic [7:0] c0, int k, int t);
    return c0 - 8'(k >> t);
  endfunction : left
  // Decrements per mode: 4 ticks pin low, 4 ticks pin high, 3 pin falls
  function logic [7:0] mdec(int m);
    return (m == 0) ? 8'h08 : (m == 1) ? 8'h04 : (m == 3) ? 8'h03 : 8'h00;
  endfunction : mdec
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h39B5465A));
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(AC, 32'h40);
    rd(AN, 32'hF0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    apb(1'b1, AN, 32'h1);
    tk(1);
    rd(AC, 32'hC0);
    chk(tmr_irq, 1'b0);
    apb(1'b1, AC, 32'h0);
    rd(AC, 32'h0);
    pulse(0);
    rd(pdct_pkg::PDCT_ADDR_STATUS, 32'h2);
    apb(1'b1, AN, 32'h2);
    tk(2);
    repeat (2) @(posedge ref_clk);
    chk({entries, vector}, 24'h011FF6);
    chk({tmr_irq, core_irq}, 2'b10);
    tk(1);
    rd(AN, 32'hFF);
    rd(AC, 32'h80);
    pulse(1);
    chk({entries, vector}, 24'h021FF8);
    apb(1'b1, AC, 32'h0);
    pulse(1);
    chk(entries, 8'h02);
    apb(1'b1, AC, 32'h83);
    apb(1'b1, AN, 32'h55);
    tk(2);
    pulse(2);
    rd(AN, 32'hF0);
    rd(AC, 32'h43);
    tk(7);
    rd(AN, 32'hF0);
    tk(1);
    rd(AN, 32'hEF);
    apb(1'b1, AC, 32'h95);
    apb(1'b1, AN, 32'h33);
    pulse(3);
    rd(AC, 32'h55);
    rd(AN, 32'h33);
    // Every input mode against the same pin and tick pattern
    for (int m = 0; m < 4; m++) begin
      tmr_pin <= 1'b0;
      apb(1'b1, AC, {24'h0, 2'b01, 2'(m), 4'h8});
      apb(1'b1, AN, 32'h80);
      tk(4);
      @(posedge ref_clk) tmr_pin <= 1'b1;
      tk(4);
      repeat (3) begin
        @(posedge ref_clk) tmr_pin <= 1'b0;
        repeat (2) @(posedge ref_clk);
        tmr_pin <= 1'b1;
        repeat (2) @(posedge ref_clk);
      end
      rd(AN, {24'h0, 8'h80 - mdec(m)});
    end
    // Random taps, loads and tick runs, prescaler cleared each time
    for (int i = 0; i < 12; i++) begin
      v = $urandom;
      c = $urandom;
      n = $urandom % 200;
      apb(1'b1, AC, {24'h0, v[7:6], 3'b001, v[2:0]});
      rd(AC, {24'h0, v[7:6], 3'b000, v[2:0]});
      apb(1'b1, AN, {24'h0, c[7:0]});
      tk(n);
      rd(AN, {24'h0, left(c[7:0], n, int'(v[2:0]))});
    end
    summarize();
  end
endmodule : prescaled_down_counter_timer_tb
`default_nettype wire
